/* src/rse_pkg.sv */
/*
  shared constants for the ramp sweep extension block: register offsets,
  field positions, reset values, ramp types and engine states.
  assumes a byte-addressed classic wishbone bus with 32-bit words.
*/
package rse_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INT_FRAC  = 8'h00;
  localparam logic [7:0] OFS_CLOCK1    = 8'h08;
  localparam logic [7:0] OFS_FUNCTION  = 8'h0c;
  localparam logic [7:0] OFS_TEST      = 8'h10;
  localparam logic [7:0] OFS_DEVIATION = 8'h14;
  localparam logic [7:0] OFS_STEP      = 8'h18;
  localparam logic [7:0] OFS_DELAY     = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;

  // field positions
  localparam int RAMP_ON_BIT     = 31;
  localparam int MUX_SEL_LSB     = 27;
  localparam int CLK1_LSB        = 3;
  localparam int CNT_RESET_BIT   = 3;
  localparam int RAMP_TYPE_LSB   = 10;
  localparam int CLK2_LSB        = 7;
  localparam int TEST_MODE_LSB   = 21;
  localparam int DEV_WORD_LSB    = 3;
  localparam int DEV_OFS_LSB     = 19;
  localparam int SET_SELECT_BIT  = 23;
  localparam int DUAL_RATE_BIT   = 24;
  localparam int SHIFT_ON_BIT    = 25;
  localparam int PARABOLIC_BIT   = 28;
  localparam int STEPS_LSB       = 3;
  localparam int DELAY_WORD_LSB  = 3;
  localparam int DELAY_START_BIT = 15;
  localparam int DELAY_CLK_BIT   = 16;
  localparam int INTER_DELAY_BIT = 17;
  localparam int DELAY_FL_BIT    = 18;

  // field codes and reset values
  localparam logic [3:0]  MUX_RAMP_DONE  = 4'hf;
  localparam logic [4:0]  TEST_RAMP_DONE = 5'h03;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {
    RSE_SAW      = 2'h0,
    RSE_TRIANGLE = 2'h1,
    RSE_SAW_ONCE = 2'h2,
    RSE_BURST    = 2'h3
  } rse_ramp_t;

  // gray along idle -> delay -> ramp -> hold
  typedef enum logic [1:0] {
    RSE_IDLE  = 2'b00,
    RSE_DELAY = 2'b01,
    RSE_RAMP  = 2'b11,
    RSE_HOLD  = 2'b10
  } rse_state_t;
endpackage : rse_pkg

/* src/rse_timer.sv */
/*
  reloading down counter of phase-compare ticks; pulses when a period ends.
  assumes tick_in is a one-cycle pulse per phase-compare period.
*/
`timescale 1ns/10ps
`default_nettype none
module rse_timer (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        run_in,
  input  wire logic [23:0] period_in,
  input  wire logic        tick_in,
  output logic             expire_out
);
  logic [23:0] cnt_r;

  // a zero period behaves as one tick
  assign expire_out = run_in && tick_in && (cnt_r <= 24'h000001);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= 24'h000000;
    end else if (!run_in || expire_out) begin
      cnt_r <= period_in;
    end else if (tick_in) begin
      cnt_r <= cnt_r - 24'h000001;
    end
  end
endmodule : rse_timer
`default_nettype wire

/* src/rse_wb_slave.sv */
/*
  classic wishbone slave front end: one wait state, registered read data.
  assumes the owner supplies read data combinationally from the address.
*/
`timescale 1ns/10ps
`default_nettype none
module rse_wb_slave (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] rd_data_in,
  output logic             wb_ack_out,
  output logic [31:0]      wb_dat_out,
  output logic             wr_stb_out,
  output logic [31:0]      wr_mask_out
);
  logic ack_r;
  logic req;

  assign req         = wb_cyc_in && wb_stb_in;
  assign wb_ack_out  = ack_r;
  // writes take effect on the edge where the master sees ack
  assign wr_stb_out  = req && wb_we_in && ack_r;
  assign wr_mask_out = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                        {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !ack_r && !wb_we_in) begin
      wb_dat_out <= rd_data_in;
    end
  end
endmodule : rse_wb_slave
`default_nettype wire

/* src/rse_ramp_ext.sv */
/*
  ramp sweep extensions: dual rates, shift on ramp, delays, fast-lock, parabolic, complete.
  assumes pfd_tick_in pulses once per phase-compare period, synchronous.
*/
// Contract
// - dual_rate_enable runs two ramps with separate step and deviation sets.
// - second-ramp settings may change mid-sweep without disturbing it.
// - deviation word, offset and set select live in deviation_register.
// - 20-bit step count and set select live in step_register.
// - shift_on_ramp_enable superimposes set-1 deviation on the linear ramp.
// - delayed_start_enable holds off the ramp start by the delay.
// - delay word counts phase-compare periods when delay_clock_select is 0.
// - delay_clock_select 1 multiplies the delay word by the first divider.
// - inter_ramp_delay_enable inserts the delay between sawtooth ramps and after each triangle period; burst holds.
// - delay_fastlock_enable gives fast-lock during the first delay only.
// - parabolic mode adds n times deviation at step n.
// - parabolic_enable written 1 turns on the parabolic sweep.
// - parabolic step timer equals the linear one.
// - parabolic span follows the triangular and burst sum formulas.
// - muxout shows ramp complete when its select and test field match.
// - ramp starts when int_frac_register bit 31 is written 1.
// - each step lasts first divider times second divider periods.
`timescale 1ns/10ps
`default_nettype none
module rse_ramp_ext (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        pfd_tick_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_ack_out,
  output logic [31:0]      wb_dat_out,
  output logic [47:0]      freq_offset_out,
  output logic             ramp_active_out,
  output logic             fastlock_out,
  output logic             muxout_out
);
  logic [31:0]         int_frac_r, clock1_r, function_r, test_r, delay_r;
  logic [15:0]         dev_word_r [2];
  logic [3:0]          dev_ofs_r [2];
  logic [19:0]         steps_r [2];
  logic                dual_en_r, shift_en_r, para_en_r;
  rse_pkg::rse_state_t state_r;
  logic                cur_set_r, dir_down_r, wrap_r, first_dly_r, cplt_r, shift_ph_r;
  logic [30:0]         seg_dev_r;
  logic [20:0]         seg_steps_r, step_cnt_r;
  logic [47:0]         acc_r, par_inc_r;
  logic [47:0]         inc;
  logic [31:0]         rd_data, wr_mask, wr_val;
  logic                wr_stb, start_req, stop_req, step_tick, dly_tick, seg_end;
  logic                cnt_reset, inter_dly, next_set;
  logic [23:0]         step_period, delay_len;
  logic [11:0]         clk1, clk2, dly_word;
  rse_pkg::rse_ramp_t  ramp_type;

  function automatic logic [23:0] mul12(input logic [11:0] a, input logic [11:0] b);
    mul12 = a * b;
  endfunction : mul12

  function automatic logic [30:0] dev_eff(input logic [15:0] w, input logic [3:0] s);
    dev_eff = {15'h0000, w} << s;
  endfunction : dev_eff

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  rse_wb_slave u_slave (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .wb_cyc_in  (wb_cyc_in),
    .wb_stb_in  (wb_stb_in),
    .wb_we_in   (wb_we_in),
    .wb_sel_in  (wb_sel_in),
    .rd_data_in (rd_data),
    .wb_ack_out (wb_ack_out),
    .wb_dat_out (wb_dat_out),
    .wr_stb_out (wr_stb),
    .wr_mask_out(wr_mask)
  );

  assign clk1      = clock1_r[rse_pkg::CLK1_LSB +: 12];
  assign clk2      = test_r[rse_pkg::CLK2_LSB +: 12];
  assign dly_word  = delay_r[rse_pkg::DELAY_WORD_LSB +: 12];
  assign ramp_type = rse_pkg::rse_ramp_t'(function_r[rse_pkg::RAMP_TYPE_LSB +: 2]);
  assign cnt_reset = function_r[rse_pkg::CNT_RESET_BIT];
  assign inter_dly = delay_r[rse_pkg::INTER_DELAY_BIT];
  assign wr_val    = wb_dat_in & wr_mask;
  assign start_req = wr_stb && (wb_adr_in == rse_pkg::OFS_INT_FRAC)
                     && wr_mask[rse_pkg::RAMP_ON_BIT] && wr_val[rse_pkg::RAMP_ON_BIT];
  assign stop_req  = wr_stb && (wb_adr_in == rse_pkg::OFS_INT_FRAC)
                     && wr_mask[rse_pkg::RAMP_ON_BIT] && !wr_val[rse_pkg::RAMP_ON_BIT];
  assign step_period = mul12(clk1, clk2);
  assign delay_len = delay_r[rse_pkg::DELAY_CLK_BIT] ? mul12(dly_word, clk1)
                                                     : {12'h000, dly_word};
  assign seg_end   = step_tick && !wrap_r && (state_r == rse_pkg::RSE_RAMP)
                     && (step_cnt_r + 21'h000001 >= seg_steps_r);
  assign next_set  = dual_en_r ? !cur_set_r : 1'b0;
  assign inc       = para_en_r ? par_inc_r + {17'h00000, seg_dev_r}
                               : {17'h00000, seg_dev_r};

  rse_timer u_step_timer (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .run_in     ((state_r == rse_pkg::RSE_RAMP) || (state_r == rse_pkg::RSE_HOLD)),
    .period_in  (step_period),
    .tick_in    (pfd_tick_in),
    .expire_out (step_tick)
  );

  rse_timer u_delay_timer (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .run_in     (state_r == rse_pkg::RSE_DELAY),
    .period_in  (delay_len),
    .tick_in    (pfd_tick_in),
    .expire_out (dly_tick)
  );

  // register writes
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      int_frac_r <= rse_pkg::REG_RESET;
      clock1_r   <= rse_pkg::REG_RESET;
      function_r <= rse_pkg::REG_RESET;
      test_r     <= rse_pkg::REG_RESET;
      delay_r    <= rse_pkg::REG_RESET;
      dual_en_r  <= 1'b0;
      shift_en_r <= 1'b0;
      para_en_r  <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        dev_word_r[i] <= 16'h0000;
        dev_ofs_r[i]  <= 4'h0;
        steps_r[i]    <= 20'h00000;
      end
    end else if (wr_stb) begin
      if (wb_adr_in == rse_pkg::OFS_INT_FRAC) begin
        int_frac_r <= merge(int_frac_r, wb_dat_in, wr_mask);
      end else if (wb_adr_in == rse_pkg::OFS_CLOCK1) begin
        clock1_r <= merge(clock1_r, wb_dat_in, wr_mask);
      end else if (wb_adr_in == rse_pkg::OFS_FUNCTION) begin
        function_r <= merge(function_r, wb_dat_in, wr_mask);
      end else if (wb_adr_in == rse_pkg::OFS_TEST) begin
        test_r <= merge(test_r, wb_dat_in, wr_mask);
      end else if (wb_adr_in == rse_pkg::OFS_DEVIATION) begin
        dev_word_r[wb_dat_in[rse_pkg::SET_SELECT_BIT]] <=
          wb_dat_in[rse_pkg::DEV_WORD_LSB +: 16];
        dev_ofs_r[wb_dat_in[rse_pkg::SET_SELECT_BIT]] <=
          wb_dat_in[rse_pkg::DEV_OFS_LSB +: 4];
        dual_en_r  <= wb_dat_in[rse_pkg::DUAL_RATE_BIT];
        shift_en_r <= wb_dat_in[rse_pkg::SHIFT_ON_BIT];
        para_en_r  <= wb_dat_in[rse_pkg::PARABOLIC_BIT];
      end else if (wb_adr_in == rse_pkg::OFS_STEP) begin
        steps_r[wb_dat_in[rse_pkg::SET_SELECT_BIT]] <=
          wb_dat_in[rse_pkg::STEPS_LSB +: 20];
      end else if (wb_adr_in == rse_pkg::OFS_DELAY) begin
        delay_r <= merge(delay_r, wb_dat_in, wr_mask);
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_in == rse_pkg::OFS_INT_FRAC) begin
      rd_data = int_frac_r;
    end else if (wb_adr_in == rse_pkg::OFS_CLOCK1) begin
      rd_data = clock1_r;
    end else if (wb_adr_in == rse_pkg::OFS_FUNCTION) begin
      rd_data = function_r;
    end else if (wb_adr_in == rse_pkg::OFS_TEST) begin
      rd_data = test_r;
    end else if (wb_adr_in == rse_pkg::OFS_DELAY) begin
      rd_data = delay_r;
    end else if (wb_adr_in == rse_pkg::OFS_STATUS) begin
      rd_data = {state_r, cur_set_r, dir_down_r, cplt_r, fastlock_out, 5'h00,
                 step_cnt_r};
    end
  end

  // sweep engine
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_r     <= rse_pkg::RSE_IDLE;
      cur_set_r   <= 1'b0;
      dir_down_r  <= 1'b0;
      wrap_r      <= 1'b0;
      first_dly_r <= 1'b0;
      cplt_r      <= 1'b0;
      shift_ph_r  <= 1'b0;
      seg_dev_r   <= 31'h0000_0000;
      seg_steps_r <= 21'h000000;
      step_cnt_r  <= 21'h000000;
      acc_r       <= 48'h0000_0000_0000;
      par_inc_r   <= 48'h0000_0000_0000;
    end else if (stop_req) begin
      state_r <= rse_pkg::RSE_IDLE;
      cplt_r  <= 1'b0;
      shift_ph_r <= 1'b0;
    end else if (cnt_reset) begin
      step_cnt_r <= 21'h000000;
      acc_r      <= 48'h0000_0000_0000;
      par_inc_r  <= 48'h0000_0000_0000;
    end else begin
      if (step_tick && !seg_end) begin
        cplt_r <= 1'b0;
      end
      case (state_r)
        rse_pkg::RSE_IDLE: begin
          if (start_req) begin
            cur_set_r   <= 1'b0;
            dir_down_r  <= 1'b0;
            wrap_r      <= 1'b0;
            seg_dev_r   <= dev_eff(dev_word_r[0], dev_ofs_r[0]);
            seg_steps_r <= {1'b0, steps_r[0]}
                           + {20'h00000, para_en_r && (ramp_type == rse_pkg::RSE_TRIANGLE)};
            step_cnt_r  <= 21'h000000;
            acc_r       <= 48'h0000_0000_0000;
            par_inc_r   <= 48'h0000_0000_0000;
            first_dly_r <= delay_r[rse_pkg::DELAY_START_BIT];
            state_r     <= delay_r[rse_pkg::DELAY_START_BIT] ? rse_pkg::RSE_DELAY
                                                             : rse_pkg::RSE_RAMP;
          end
        end
        rse_pkg::RSE_DELAY: begin
          if (dly_tick) begin
            first_dly_r <= 1'b0;
            state_r     <= rse_pkg::RSE_RAMP;
          end
        end
        rse_pkg::RSE_RAMP: begin
          if (step_tick) begin
            shift_ph_r <= !shift_ph_r;
            if (wrap_r) begin
              wrap_r     <= 1'b0;
              acc_r      <= 48'h0000_0000_0000;
              step_cnt_r <= 21'h000000;
              if (ramp_type == rse_pkg::RSE_SAW_ONCE) begin
                state_r <= rse_pkg::RSE_HOLD;
              end else if (inter_dly) begin
                state_r <= rse_pkg::RSE_DELAY;
              end
            end else begin
              acc_r      <= dir_down_r ? acc_r - inc : acc_r + inc;
              par_inc_r  <= para_en_r ? inc : par_inc_r;
              step_cnt_r <= step_cnt_r + 21'h000001;
            end
            if (seg_end) begin
              cplt_r     <= 1'b1;
              step_cnt_r <= 21'h000000;
              par_inc_r  <= 48'h0000_0000_0000;
              cur_set_r  <= next_set;
              seg_dev_r  <= dev_eff(dev_word_r[next_set], dev_ofs_r[next_set]);
              seg_steps_r <= {1'b0, steps_r[next_set]}
                             + {20'h00000, para_en_r && (ramp_type == rse_pkg::RSE_TRIANGLE)};
              if (ramp_type == rse_pkg::RSE_TRIANGLE) begin
                dir_down_r <= !dir_down_r;
                if (dir_down_r && inter_dly) begin
                  state_r <= rse_pkg::RSE_DELAY;
                end
              end else if (ramp_type == rse_pkg::RSE_BURST) begin
                state_r <= rse_pkg::RSE_HOLD;
              end else begin
                wrap_r <= 1'b1;
              end
            end
          end
        end
        rse_pkg::RSE_HOLD: begin
          state_r <= rse_pkg::RSE_HOLD;
        end
        default: begin
          state_r <= rse_pkg::RSE_IDLE;
        end
      endcase
    end
  end

  // output pins
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      freq_offset_out <= 48'h0000_0000_0000;
      muxout_out      <= 1'b0;
    end else begin
      freq_offset_out <= acc_r + ((shift_en_r && shift_ph_r)
                         ? {17'h00000, dev_eff(dev_word_r[1], dev_ofs_r[1])}
                         : 48'h0000_0000_0000);
      muxout_out <= cplt_r
                    && (int_frac_r[rse_pkg::MUX_SEL_LSB +: 4] == rse_pkg::MUX_RAMP_DONE)
                    && (test_r[rse_pkg::TEST_MODE_LSB +: 5] == rse_pkg::TEST_RAMP_DONE);
    end
  end
  assign ramp_active_out = (state_r != rse_pkg::RSE_IDLE);
  assign fastlock_out    = (state_r == rse_pkg::RSE_DELAY) && first_dly_r
                           && delay_r[rse_pkg::DELAY_FL_BIT];

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  property p_idle_holds;
    (state_r == rse_pkg::RSE_IDLE) && !start_req |=> (state_r == rse_pkg::RSE_IDLE);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("sweep left idle unasked");

  property p_delayed_start;
    (state_r == rse_pkg::RSE_IDLE) && start_req && !stop_req && !cnt_reset
      && delay_r[rse_pkg::DELAY_START_BIT] |=> (state_r == rse_pkg::RSE_DELAY);
  endproperty
  a_delayed_start: assert property (p_delayed_start) else $error("start not delayed");

  property p_direct_start;
    (state_r == rse_pkg::RSE_IDLE) && start_req && !stop_req && !cnt_reset
      && !delay_r[rse_pkg::DELAY_START_BIT] |=> (state_r == rse_pkg::RSE_RAMP);
  endproperty
  a_direct_start: assert property (p_direct_start) else $error("start was delayed");

  property p_cplt_set;
    seg_end && !stop_req && !cnt_reset |=> cplt_r;
  endproperty
  a_cplt_set: assert property (p_cplt_set) else $error("ramp complete missing");

  property p_cplt_clear;
    cplt_r && step_tick && !seg_end && !cnt_reset |=> !cplt_r;
  endproperty
  a_cplt_clear: assert property (p_cplt_clear) else $error("ramp complete too long");

  property p_dual_swap;
    seg_end && dual_en_r && !stop_req && !cnt_reset |=> (cur_set_r != $past(cur_set_r));
  endproperty
  a_dual_swap: assert property (p_dual_swap) else $error("set did not alternate");

  property p_fastlock_window;
    fastlock_out |-> (state_r == rse_pkg::RSE_DELAY) && first_dly_r;
  endproperty
  a_fastlock_window: assert property (p_fastlock_window) else $error("fast-lock outside");

  property p_mux_source;
    muxout_out |-> $past(cplt_r);
  endproperty
  a_mux_source: assert property (p_mux_source) else $error("muxout without complete");

  property p_parabolic_growth;
    (state_r == rse_pkg::RSE_RAMP) && step_tick && !wrap_r && !seg_end && para_en_r
      && !stop_req && !cnt_reset |=> par_inc_r == $past(par_inc_r) + {17'h00000, $past(seg_dev_r)};
  endproperty
  a_parabolic_growth: assert property (p_parabolic_growth) else $error("bad increment");

  property p_shadow_steps;
    (state_r == rse_pkg::RSE_RAMP) && !seg_end && !start_req |=> $stable(seg_steps_r);
  endproperty
  a_shadow_steps: assert property (p_shadow_steps) else $error("sweep disturbed");

  c_delay: cover property ((state_r == rse_pkg::RSE_DELAY) ##1 (state_r == rse_pkg::RSE_RAMP));
  c_dual:  cover property (seg_end && dual_en_r);
  c_mux:   cover property (muxout_out);
endmodule : rse_ramp_ext
`default_nettype wire

/* sim/rse_host_model.sv */
/*
  host model: classic wishbone master issuing single register cycles.
  assumes a slave that acks each access and drops ack the cycle after.
*/
`timescale 1ns/10ps
`default_nettype none
module rse_host_model (
  input  wire logic        sys_clk_in,
  input  wire logic        wb_ack_in,
  input  wire logic [31:0] wb_dat_in,
  output var logic         wb_cyc_out,
  output var logic         wb_stb_out,
  output var logic         wb_we_out,
  output var logic [7:0]   wb_adr_out,
  output var logic [3:0]   wb_sel_out,
  output var logic [31:0]  wb_dat_out
);
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out  = 1'b0;
    wb_adr_out = 8'h00;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h0;
  end

  // raise all, hold until ack sampled, then release; stale data inverted
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
    @(posedge sys_clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out  <= we;
    wb_adr_out <= adr;
    wb_sel_out <= 4'hf;
    wb_dat_out <= dat;
    do begin
      @(posedge sys_clk_in);
    end while (wb_ack_in !== 1'b1);
    q = wb_dat_in;
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_we_out  <= 1'b0;
    wb_dat_out <= ~dat;
  endtask : xfer
endmodule : rse_host_model
`default_nettype wire

/* sim/rse_ramp_ext_tb.sv */
/*
  testbench for the ramp sweep extensions, driven through the host model.
  assumes a 100 mhz clock and a phase-compare tick every 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t %s", $time, m); end end
module rse_ramp_ext_tb;
  logic        sys_clk_in, reset_in, pfd_tick_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic        wb_ack_out, ramp_active_out, fastlock_out, muxout_out;
  logic [47:0] freq_offset_out;
  logic [1:0]  tick_cnt;
  int          fails, compares, cycles;

  rse_ramp_ext dut_u (.sys_clk_in, .reset_in, .pfd_tick_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .wb_dat_out,
    .freq_offset_out, .ramp_active_out, .fastlock_out, .muxout_out);
  rse_host_model host_u (.sys_clk_in, .wb_ack_in(wb_ack_out), .wb_dat_in(wb_dat_out),
    .wb_cyc_out(wb_cyc_in), .wb_stb_out(wb_stb_in), .wb_we_out(wb_we_in),
    .wb_adr_out(wb_adr_in), .wb_sel_out(wb_sel_in), .wb_dat_out(wb_dat_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    tick_cnt = 2'h0;
    pfd_tick_in = 1'b0;
  end
  always @(posedge sys_clk_in) begin
    tick_cnt <= tick_cnt + 2'h1;
    pfd_tick_in <= (tick_cnt == 2'h3);
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    host_u.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // clk1 = 2, clk2 = 3, complete on muxout, counter reset pulsed
  task automatic setup(input logic [31:0] dly, stp, dev, fn);
    wr(rse_pkg::OFS_DELAY, dly);
    wr(rse_pkg::OFS_STEP, stp);
    wr(rse_pkg::OFS_DEVIATION, dev);
    wr(rse_pkg::OFS_TEST, 32'h0060_0180);
    wr(rse_pkg::OFS_FUNCTION, fn | 32'h8);
    wr(rse_pkg::OFS_FUNCTION, fn);
    wr(rse_pkg::OFS_CLOCK1, 32'h10);
  endtask : setup

  task automatic wait_change(output int n);
    logic [47:0] v;
    v = freq_offset_out;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while (freq_offset_out === v && n < 300);
  endtask : wait_change

  task automatic reset_chk;
    logic [31:0] q;
    `CHK(freq_offset_out, 48'h0, "offset after reset");
    `CHK(muxout_out, 1'b0, "muxout after reset");
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, q);
    `CHK(q, 32'h0, "unmapped read");
    wr(rse_pkg::OFS_DEVIATION, 32'h0000_0008);
    rd(rse_pkg::OFS_DEVIATION, q);
    `CHK(q, 32'h0, "deviation write only");
    rd(rse_pkg::OFS_STATUS, q);
    `CHK(q[31:30], 2'b00, "config alone idle");
  endtask : reset_chk

  task automatic dual_run;
    logic [31:0] q;
    setup(32'h0, 32'h10, 32'h0100_0008, 32'h0);
    wr(rse_pkg::OFS_STEP, 32'h0080_0018);
    wr(rse_pkg::OFS_DEVIATION, 32'h0180_0010);
    wr(rse_pkg::OFS_INT_FRAC, 32'hf800_0000);
    wr(rse_pkg::OFS_STEP, 32'h0080_0020);
    rd(rse_pkg::OFS_STATUS, q);
    `CHK(q[29], 1'b0, "first set active");
    repeat (56) @(posedge sys_clk_in);
    rd(rse_pkg::OFS_STATUS, q);
    `CHK(q[29], 1'b1, "second set after count");
    wr(rse_pkg::OFS_INT_FRAC, 32'h0);
  endtask : dual_run

  task automatic delay_run(input logic sel, input logic [1:0] exp);
    logic [31:0] q;
    setup(32'h0004_8028 | (32'(sel) << 16), 32'h20, 32'h8, 32'hc00);
    `CHK(ramp_active_out, 1'b0, "idle before start");
    wr(rse_pkg::OFS_INT_FRAC, 32'hf800_0000);
    repeat (2) @(posedge sys_clk_in);
    #1;
    `CHK(fastlock_out, 1'b1, "fastlock in delay");
    repeat (28) @(posedge sys_clk_in);
    rd(rse_pkg::OFS_STATUS, q);
    `CHK(q[31:30], exp, "delay length");
    if (!sel) `CHK(fastlock_out, 1'b0, "fastlock after delay");
    wr(rse_pkg::OFS_INT_FRAC, 32'h0);
  endtask : delay_run

  task automatic run_span(input logic [31:0] dev, fn, shf, input int exp);
    int n, w;
    logic [47:0] mx;
    setup(32'h0, 32'h20, dev, fn);
    if (shf != 32'h0) wr(rse_pkg::OFS_DEVIATION, shf);
    wr(rse_pkg::OFS_INT_FRAC, 32'hf800_0000);
    wait_change(n);
    wait_change(n);
    wait_change(n);
    `CHK(n, 24, "step interval");
    mx = 48'h0;
    w = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk_in);
      #1;
      if ($signed(freq_offset_out) > $signed(mx)) mx = freq_offset_out;
      if (muxout_out === 1'b1) w++;
      else if (w > 0) break;
    end
    `CHK(mx, 48'(exp), "span");
    `CHK(w, 24, "complete width");
    wr(rse_pkg::OFS_INT_FRAC, 32'h0);
  endtask : run_span

  initial begin
    reset_in = 1'b1;
    fails = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    reset_chk();
    dual_run();
    delay_run(1'b0, 2'b11);
    delay_run(1'b1, 2'b01);
    run_span(32'h0000_0008, 32'hc00, 32'h0, 4);
    run_span(32'h0000_0008, 32'hc00, 32'h0280_0010, 5);
    run_span(32'h1000_0008, 32'hc00, 32'h0, 10);
    run_span(32'h1000_0008, 32'h400, 32'h0, 15);
    stop_test();
  end
endmodule : rse_ramp_ext_tb
`default_nettype wire
